/* hdl/csf_pkg.sv */
package csf_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [3:0] CSF_ADDR_FLAGS = 4'h0;
	localparam logic [3:0] CSF_ADDR_IRQ_STAT = 4'h1;
	localparam logic [3:0] CSF_ADDR_IRQ_EN = 4'h2;
	localparam logic [3:0] CSF_ADDR_IRQ_CLR = 4'h3;
	// ************************************************************
	// Flag bit positions
	// ************************************************************
	localparam int CSF_B_CARRY = 0;
	localparam int CSF_B_NIBBLE = 1;
	localparam int CSF_B_NULL = 2;
	localparam int CSF_B_WRAP = 3;
	localparam int CSF_B_SLEEP = 4;
	localparam int CSF_B_WDT = 5;
	localparam int CSF_B_LNIL = 6;
	localparam int CSF_B_SXOR = 7;
	localparam logic [7:0] CSF_ARITH_MASK = 8'hCF;
	// Undefined arithmetic flags: zeros chosen for a deterministic model
	localparam logic [7:0] CSF_FLAGS_RST = 8'h00;
	// Interrupt status bits
	localparam int CSF_I_WDT = 0;
	localparam int CSF_I_HALT = 1;
	localparam int CSF_I_NULL = 2;
	localparam int CSF_I_WRAP = 3;
	localparam logic [3:0] CSF_IRQ_RST = 4'h0;
	// ************************************************************
	// Operation classes
	// ************************************************************
	typedef enum logic [2:0]
	{
		CSF_OP_NONE = 3'b000,
		CSF_OP_ADD = 3'b001,
		CSF_OP_SUB = 3'b010,
		CSF_OP_SBC = 3'b011,
		CSF_OP_LOGIC = 3'b100,
		CSF_OP_ROT = 3'b101
	} csf_op_e;
endpackage

/* hdl/csf_adder.sv */
`timescale 1ns/1ps
`default_nettype none
module csf_adder
	import csf_pkg::*;
(
	input  wire logic [7:0] a_i,
	input  wire logic [7:0] b_i,
	input  wire logic       cin_i,
	input  wire logic       sub_i,
	output logic      [7:0] sum_o,
	output logic            cout_o,
	output logic            nib_o,
	output logic            c7_o
);
	// ************************************************************
	// Subtract as a plus inverted b plus carry: carry out means no borrow
	// ************************************************************
	wire logic [7:0] b_eff = sub_i ? ~b_i : b_i;
	wire logic [4:0] low   = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]}
		+ {4'h0, cin_i};
	wire logic [7:0] low7  = {1'b0, a_i[6:0]} + {1'b0, b_eff[6:0]}
		+ {7'h00, cin_i};
	wire logic [8:0] full  = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, cin_i};
	assign sum_o  = full[7:0];
	assign cout_o = full[8];
	assign nib_o  = low[4];
	assign c7_o   = low7[7];
endmodule
`default_nettype wire

/* hdl/csf_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module csf_irq
	import csf_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] event_i,
	input  wire logic [3:0] clear_i,
	input  wire logic [3:0] enable_i,
	output logic      [3:0] status_o,
	output logic            irq_o
);
	// Set beats clear so an event in the clearing cycle is kept
	wire logic [3:0] next_status = (status_o & ~clear_i) | event_i;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_o <= CSF_IRQ_RST;
		else
			status_o <= next_status;
	end
	assign irq_o = |(status_o & enable_i);
endmodule
`default_nettype wire

/* hdl/csf_flags.sv */
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module csf_flags
	import csf_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       exec_i,
	input  wire logic [2:0] op_i,
	input  wire logic [7:0] a_i,
	input  wire logic [7:0] b_i,
	input  wire logic       use_carry_i,
	input  wire logic [7:0] logic_res_i,
	input  wire logic       rot_carry_i,
	input  wire logic       wdt_timeout_i,
	input  wire logic       wdt_refresh_i,
	input  wire logic       halt_i,
	output logic      [7:0] result_o,
	output logic      [7:0] flags_o,
	input  wire logic [3:0] avs_address,
	input  wire logic       avs_read,
	input  wire logic       avs_write,
	input  wire logic [7:0] avs_writedata,
	output logic      [7:0] avs_readdata,
	output logic            avs_waitrequest,
	output logic            irq_o
);
	// ************************************************************
	// Datapath
	// ************************************************************
	logic [7:0] flags;
	logic [3:0] irq_en;
	logic [3:0] irq_stat;
	logic       rd_done;
	wire logic [7:0] sum;
	wire logic       cout;
	wire logic       nib;
	wire logic       c7;
	wire logic is_add   = op_i == CSF_OP_ADD;
	wire logic is_sub   = op_i == CSF_OP_SUB;
	wire logic is_sbc   = op_i == CSF_OP_SBC;
	wire logic is_arith = is_add | is_sub | is_sbc;
	wire logic is_logic = op_i == CSF_OP_LOGIC;
	wire logic is_rot   = op_i == CSF_OP_ROT;
	// Plain subtract injects carry 1 (no borrow); sbc uses the stored carry
	wire logic cin = is_sub ? 1'b1
		: (use_carry_i | is_sbc) & flags[CSF_B_CARRY];
	csf_adder u_add
	(
		.a_i    (a_i),
		.b_i    (b_i),
		.cin_i  (cin),
		.sub_i  (is_sub | is_sbc),
		.sum_o  (sum),
		.cout_o (cout),
		.nib_o  (nib),
		.c7_o   (c7)
	);
	wire logic [7:0] res  = is_arith ? sum : logic_res_i;
	wire logic       zero = res == 8'h00;
	wire logic       wrap = c7 ^ cout;
	// ************************************************************
	// Next flag value
	// ************************************************************
	wire logic bus_wr  = avs_write & (avs_address == CSF_ADDR_FLAGS);
	wire logic do_exec = exec_i & (is_arith | is_logic | is_rot);
	logic [7:0] next_flags;
	always_comb
	begin
		next_flags = flags;
		if (bus_wr)
			next_flags = (flags & ~CSF_ARITH_MASK)
				| (avs_writedata & CSF_ARITH_MASK);
		else if (do_exec)
		begin
			// Unaffected bits keep their value
			if (is_arith)
			begin
				next_flags[CSF_B_CARRY]  = cout;
				next_flags[CSF_B_NIBBLE] = nib;
				next_flags[CSF_B_WRAP]   = wrap;
				next_flags[CSF_B_SXOR]   = wrap ^ res[7];
			end
			if (is_rot)
				next_flags[CSF_B_CARRY] = rot_carry_i;
			if (is_arith | is_logic)
				next_flags[CSF_B_NULL] = zero;
			if (is_sub)
				next_flags[CSF_B_LNIL] = zero;
			else if (is_sbc)
				next_flags[CSF_B_LNIL] = flags[CSF_B_LNIL] & zero;
			// Other classes leave linked-nil alone
		end
		// System flags: refresh and halt dominate time-out
		if (wdt_refresh_i | halt_i)
			next_flags[CSF_B_WDT] = 1'b0;
		else if (wdt_timeout_i)
			next_flags[CSF_B_WDT] = 1'b1;
		if (halt_i)
			next_flags[CSF_B_SLEEP] = 1'b1;
		else if (wdt_refresh_i)
			next_flags[CSF_B_SLEEP] = 1'b0;
	end
	// No stack save of flags lives here; software must do it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flags <= CSF_FLAGS_RST;
		else
			flags <= next_flags;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			result_o <= 8'h00;
		else if (exec_i & (is_arith | is_logic))
			result_o <= res;
	end
	assign flags_o = flags;
	// ************************************************************
	// Interrupts
	// ************************************************************
	wire logic [3:0] irq_evt = {
		do_exec & (is_arith | is_logic) & wrap & is_arith,
		do_exec & (is_arith | is_logic) & zero,
		halt_i,
		wdt_timeout_i & ~wdt_refresh_i & ~halt_i};
	wire logic [3:0] irq_clr = (avs_write & (avs_address == CSF_ADDR_IRQ_CLR))
		? avs_writedata[3:0] : 4'h0;
	csf_irq u_irq
	(
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.event_i  (irq_evt),
		.clear_i  (irq_clr),
		.enable_i (irq_en),
		.status_o (irq_stat),
		.irq_o    (irq_o)
	);
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_en <= CSF_IRQ_RST;
		else if (avs_write & (avs_address == CSF_ADDR_IRQ_EN))
			irq_en <= avs_writedata[3:0];
	end
	// ************************************************************
	// Avalon slave: writes in one cycle, reads wait one cycle
	// ************************************************************
	wire logic [7:0] rd_mux =
		(avs_address == CSF_ADDR_FLAGS)    ? flags :
		(avs_address == CSF_ADDR_IRQ_STAT) ? {4'h0, irq_stat} :
		(avs_address == CSF_ADDR_IRQ_EN)   ? {4'h0, irq_en} : 8'h00;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rd_done <= 1'b0;
		else
			rd_done <= avs_read & ~rd_done;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			avs_readdata <= 8'h00;
		else if (avs_read & ~rd_done)
			avs_readdata <= rd_mux;
	end
	assign avs_waitrequest = avs_read & ~rd_done;
	// ************************************************************
	// Assertions
	// ************************************************************
	a_wdt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(wdt_refresh_i | halt_i) |=> !flags[CSF_B_WDT])
		else $error("watchdog flag not cleared");
	a_wdt_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(wdt_timeout_i & !wdt_refresh_i & !halt_i) |=> flags[CSF_B_WDT])
		else $error("watchdog flag not set");
	a_sleep_set: assert property (@(posedge clk_i) disable iff (rst_i)
		halt_i |=> flags[CSF_B_SLEEP])
		else $error("sleep flag not set on halt");
	a_sys_stable: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wdt_refresh_i | halt_i | wdt_timeout_i) |=>
		flags[5:4] == $past(flags[5:4]))
		else $error("system flag changed");
	a_null_track: assert property (@(posedge clk_i) disable iff (rst_i)
		(do_exec & !bus_wr & (is_arith | is_logic)) |=>
		flags[CSF_B_NULL] == (result_o == 8'h00))
		else $error("null flag wrong");
	a_sxor_rel: assert property (@(posedge clk_i) disable iff (rst_i)
		(do_exec & !bus_wr & is_arith) |=>
		flags[CSF_B_SXOR] == (flags[CSF_B_WRAP] ^ result_o[7]))
		else $error("sign xor wrong");
	a_lnil_sub: assert property (@(posedge clk_i) disable iff (rst_i)
		(do_exec & !bus_wr & is_sub) |=>
		flags[CSF_B_LNIL] == flags[CSF_B_NULL])
		else $error("linked nil not copied");
	a_lnil_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(!bus_wr & !(exec_i & (is_sub | is_sbc))) |=>
		$stable(flags[CSF_B_LNIL]))
		else $error("linked nil changed");
	a_carry_add: assert property (@(posedge clk_i) disable iff (rst_i)
		(do_exec & !bus_wr & is_add & !use_carry_i) |=>
		flags[CSF_B_CARRY] == ((9'($past(a_i)) + 9'($past(b_i))) > 9'h0FF))
		else $error("carry wrong");
	a_sleep_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(wdt_refresh_i & !halt_i) |=> !flags[CSF_B_SLEEP])
		else $error("sleep flag not cleared");
	a_lnil_chain: assert property (@(posedge clk_i) disable iff (rst_i)
		(do_exec & !bus_wr & is_sbc) |=>
		flags[CSF_B_LNIL] == ($past(flags[CSF_B_LNIL]) & flags[CSF_B_NULL]))
		else $error("linked nil chain wrong");
	a_arith_write: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_wr |=>
		(flags & CSF_ARITH_MASK) == ($past(avs_writedata) & CSF_ARITH_MASK))
		else $error("flag write not applied");
	// A read waits exactly one cycle, then its data stand at the answer
	sequence s_rd_start;
		avs_read & !rd_done;
	endsequence
	sequence s_rd_answer;
		!avs_waitrequest;
	endsequence
	a_read_wait: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rd_start |=> s_rd_answer)
		else $error("read answer late");
	a_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_rd_start ##0 (avs_address == CSF_ADDR_FLAGS)) |=>
		avs_readdata == $past(flags))
		else $error("read data wrong");
endmodule
`default_nettype wire

/* test/csf_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module csf_core_model
(
	input  wire logic       clk_i,
	output logic            exec_o,
	output logic      [2:0] op_o,
	output logic      [7:0] a_o,
	output logic      [7:0] b_o,
	output logic            use_carry_o,
	output logic      [7:0] logic_res_o,
	output logic            rot_carry_o,
	output logic      [2:0] event_o
);
	// ************************************************************
	// Execute stage: one instruction and its system events per call
	// ************************************************************
	initial
	begin
		{exec_o, op_o, a_o, b_o, use_carry_o} = '0;
		{logic_res_o, rot_carry_o, event_o} = '0;
	end

	// Pulses last one cycle, so an event is never counted twice
	task automatic issue(input logic [2:0] op, input logic [7:0] a, b,
		input logic uc, input logic [7:0] lr, input logic rc,
		input logic [2:0] ev);
		@(posedge clk_i);
		exec_o <= (op != 3'h0);
		{op_o, a_o, b_o, use_carry_o} <= {op, a, b, uc};
		{logic_res_o, rot_carry_o, event_o} <= {lr, rc, ev};
		@(posedge clk_i);
		exec_o <= 1'b0;
		event_o <= 3'h0;
	endtask
endmodule
`default_nettype wire

/* test/cpu_status_flags_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flags_test;
	import csf_pkg::*;
	logic       clk_i;
	logic       rst_i = 1'b1;
	logic       exec, uc, rc, rd, wr, wreq, irq;
	logic [2:0] op, ev;
	logic [7:0] a, b, lr, result, flags, wdata, rdata;
	logic [3:0] addr;
	int         miscompares = 0;
	int         n_checks = 0;

	initial
	begin
		{rd, wr, addr, wdata} = '0;
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	csf_core_model i_csf_core_model (.clk_i(clk_i), .exec_o(exec),
		.op_o(op), .a_o(a), .b_o(b), .use_carry_o(uc),
		.logic_res_o(lr), .rot_carry_o(rc), .event_o(ev));

	csf_flags i_csf_flags (.clk_i(clk_i), .rst_i(rst_i), .exec_i(exec),
		.op_i(op), .a_i(a), .b_i(b), .use_carry_i(uc), .logic_res_i(lr),
		.rot_carry_i(rc), .wdt_timeout_i(ev[0]), .wdt_refresh_i(ev[1]),
		.halt_i(ev[2]), .result_o(result), .flags_o(flags),
		.avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .irq_o(irq));

	// ************************************************************
	// Access and compare tasks
	// ************************************************************
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmp8(input logic [7:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Request held until waitrequest is sampled low at an edge
	task automatic bus(input logic w, input logic [3:0] ad,
		input logic [7:0] wd, output logic [7:0] d);
		@(posedge clk_i);
		{addr, wr, rd, wdata} <= {ad, w, !w, wd};
		for (int n = 0; n < 20; n++)
		begin
			@(posedge clk_i);
			if (wreq === 1'b0)
				break;
			if (n == 19)
			begin
				miscompares++;
				$display("unexpected at %0t: bus answer timed out", $time);
			end
		end
		d = rdata;
		{wr, rd} <= 2'b00;
	endtask

	task automatic rdc(input logic [3:0] ad, input logic [7:0] exp);
		logic [7:0] d;
		bus(1'b0, ad, 8'h00, d);
		cmp8(d, exp);
	endtask

	// Write, then look at the interrupt line once the edge has landed
	task automatic wirq(input logic [3:0] ad, input logic [7:0] wd,
		input logic exp_irq);
		logic [7:0] d;
		bus(1'b1, ad, wd, d);
		@(negedge clk_i);
		cmp8({7'h00, irq}, {7'h00, exp_irq});
	endtask

	// ctl = {use carry, halt, refresh, time-out}; logic result = a
	task automatic ex(input logic [2:0] o, input logic [7:0] x, y,
		input logic [3:0] ctl, input logic [7:0] ef, er);
		i_csf_core_model.issue(o, x, y, ctl[3], x, y[0], ctl[2:0]);
		@(negedge clk_i);
		cmp8(flags, ef);
		if (o inside {3'h1, 3'h2, 3'h3, 3'h4})
			cmp8(result, er);
	endtask

	initial
	begin
		#500000;
		miscompares++;
		complete_run();
	end

	// ************************************************************
	// Tests
	// ************************************************************
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(CSF_ADDR_FLAGS, 8'h00);
		rdc(CSF_ADDR_IRQ_STAT, 8'h00);
		ex(3'h1, 8'h7F, 8'h01, 4'h0, 8'h0A, 8'h80);
		ex(3'h1, 8'hFF, 8'h01, 4'h0, 8'h07, 8'h00);
		ex(3'h1, 8'h0F, 8'h00, 4'h8, 8'h02, 8'h10);
		ex(3'h2, 8'h05, 8'h05, 4'h0, 8'h47, 8'h00);
		ex(3'h2, 8'h05, 8'h06, 4'h0, 8'h80, 8'hFF);
		ex(3'h5, 8'h00, 8'h01, 4'h0, 8'h81, 8'h00);
		ex(3'h2, 8'h03, 8'h03, 4'h0, 8'h47, 8'h00);
		ex(3'h3, 8'h03, 8'h02, 4'h0, 8'h03, 8'h01);
		ex(3'h3, 8'h00, 8'h00, 4'h0, 8'h07, 8'h00);
		ex(3'h4, 8'h5A, 8'h00, 4'h0, 8'h03, 8'h5A);
		ex(3'h5, 8'h00, 8'h00, 4'h0, 8'h02, 8'h00);
		ex(3'h0, 8'h00, 8'h00, 4'h1, 8'h22, 8'h00);
		ex(3'h0, 8'h00, 8'h00, 4'h4, 8'h12, 8'h00);
		ex(3'h0, 8'h00, 8'h00, 4'h2, 8'h02, 8'h00);
		ex(3'h0, 8'h00, 8'h00, 4'h1, 8'h22, 8'h00);
		ex(3'h0, 8'h00, 8'h00, 4'h5, 8'h12, 8'h00);
		wirq(CSF_ADDR_FLAGS, 8'hFF, 1'b0);
		rdc(CSF_ADDR_FLAGS, 8'hDF);
		wirq(CSF_ADDR_FLAGS, 8'h00, 1'b0);
		rdc(CSF_ADDR_FLAGS, 8'h10);
		ex(3'h1, 8'hFF, 8'hFF, 4'h0, 8'h93, 8'hFE);
		wirq(CSF_ADDR_FLAGS, 8'h10, 1'b0);
		rdc(CSF_ADDR_FLAGS, 8'h10);
		rdc(CSF_ADDR_IRQ_STAT, 8'h0F);
		wirq(CSF_ADDR_IRQ_EN, 8'h02, 1'b1);
		wirq(CSF_ADDR_IRQ_CLR, 8'h02, 1'b0);
		rdc(CSF_ADDR_IRQ_STAT, 8'h0D);
		rdc(4'h5, 8'h00);
		wirq(CSF_ADDR_IRQ_EN, 8'h0F, 1'b1);
		wirq(CSF_ADDR_IRQ_CLR, 8'h0F, 1'b0);
		rdc(CSF_ADDR_IRQ_STAT, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire
